//--- design/rtc_alarm_pkg.sv
package rtc_alarm_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CLK_CFG = 8'h00;
   localparam logic [7:0] OFS_PAD_CFG = 8'h04;
   localparam logic [7:0] OFS_ALM_CFG = 8'h08;
   localparam logic [7:0] OFS_ALM_VAL = 8'h0C;
   localparam logic [7:0] OFS_MIN_SEC = 8'h10;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

   // ----------------------------------------------------------------
   // Clock configuration and calibration fields
   // ----------------------------------------------------------------
   localparam int CFG_ENABLE_BIT = 15;
   localparam int CFG_UNLOCK_BIT = 13;
   localparam int CFG_HALF_SEC_BIT = 11;
   localparam int CFG_PIN_OE_BIT = 10;
   localparam int CAL_MSB = 7;
   localparam logic [15:0] CFG_WRITE_MASK = 16'h27FF;
   localparam logic [15:0] CFG_RESET = 16'h0000;

   // ----------------------------------------------------------------
   // Pad configuration fields
   // ----------------------------------------------------------------
   localparam int PAD_SRC_SEL_BIT = 1;
   localparam int PAD_PORT_BUF_BIT = 0;
   localparam logic [15:0] PAD_WRITE_MASK = 16'h0003;
   localparam logic [15:0] PAD_RESET = 16'h0000;

   // ----------------------------------------------------------------
   // Alarm configuration and repeat fields
   // ----------------------------------------------------------------
   localparam int ALM_ENABLE_BIT = 15;
   localparam int ALM_WRAP_BIT = 14;
   localparam int ALM_MASK_MSB = 13;
   localparam int ALM_MASK_LSB = 10;
   localparam int ALM_PTR_MSB = 9;
   localparam int ALM_PTR_LSB = 8;
   localparam int ALM_RPT_MSB = 7;
   localparam logic [15:0] ALM_RESET = 16'h0000;
   localparam logic [7:0] RPT_LAST = 8'h00;
   localparam logic [7:0] RPT_WRAP_VALUE = 8'hFF;
   localparam logic [7:0] RPT_STEP = 8'h01;

   // ----------------------------------------------------------------
   // Alarm window pointer codes and field masks
   // ----------------------------------------------------------------
   localparam logic [1:0] PTR_MIN_SEC = 2'b00;
   localparam logic [1:0] PTR_WDAY_HOUR = 2'b01;
   localparam logic [1:0] PTR_MONTH_DAY = 2'b10;
   localparam logic [1:0] PTR_STEP = 2'b01;
   localparam logic [15:0] MIN_SEC_MASK = 16'h7F7F;
   localparam logic [15:0] WDAY_HOUR_MASK = 16'h073F;
   localparam logic [15:0] MONTH_DAY_MASK = 16'h1F3F;

   // ----------------------------------------------------------------
   // Alarm interval mask codes
   // ----------------------------------------------------------------
   localparam logic [3:0] IVL_HALF_SEC = 4'h0;
   localparam logic [3:0] IVL_SEC = 4'h1;
   localparam logic [3:0] IVL_TEN_SEC = 4'h2;
   localparam logic [3:0] IVL_MINUTE = 4'h3;
   localparam logic [3:0] IVL_TEN_MIN = 4'h4;
   localparam logic [3:0] IVL_HOUR = 4'h5;
   localparam logic [3:0] IVL_DAY = 4'h6;
   localparam logic [3:0] IVL_WEEK = 4'h7;
   localparam logic [3:0] IVL_MONTH = 4'h8;
   localparam logic [3:0] IVL_YEAR = 4'h9;

   // ----------------------------------------------------------------
   // Interrupt status layout
   // ----------------------------------------------------------------
   localparam int IRQ_ALARM_BIT = 0;
   localparam logic [15:0] IRQ_WRITE_MASK = 16'h0001;

endpackage

//--- design/alarm_match_if.sv
`timescale 1ns/100ps
`default_nettype none
interface alarm_match_if;
   logic [3:0] interval_mask;
   logic [15:0] alarm_min_sec;
   logic [15:0] alarm_wday_hour;
   logic [15:0] alarm_month_day;
   logic [15:0] now_min_sec;
   logic [15:0] now_wday_hour;
   logic [15:0] now_month_day;
   logic half_tick;
   logic sec_tick;
   logic match;

   modport owner (
      output interval_mask, alarm_min_sec, alarm_wday_hour, alarm_month_day,
      output now_min_sec, now_wday_hour, now_month_day, half_tick, sec_tick,
      input match
   );
   modport matcher (
      input interval_mask, alarm_min_sec, alarm_wday_hour, alarm_month_day,
      input now_min_sec, now_wday_hour, now_month_day, half_tick, sec_tick,
      output match
   );
endinterface
`default_nettype wire

//--- design/alarm_matcher.sv
`timescale 1ns/100ps
`default_nettype none
module alarm_matcher
   import rtc_alarm_pkg::*;
(
   // Comparison carrier
   alarm_match_if.matcher m
);

   logic sec_one_hit;
   logic sec_hit;
   logic min_one_hit;
   logic min_hit;
   logic hour_hit;
   logic wday_hit;
   logic day_hit;
   logic month_hit;

   assign sec_one_hit = m.alarm_min_sec[3:0] == m.now_min_sec[3:0];
   assign sec_hit = m.alarm_min_sec[6:0] == m.now_min_sec[6:0];
   assign min_one_hit = m.alarm_min_sec[11:8] == m.now_min_sec[11:8];
   assign min_hit = m.alarm_min_sec[14:8] == m.now_min_sec[14:8];
   assign hour_hit = m.alarm_wday_hour[5:0] == m.now_wday_hour[5:0];
   assign wday_hit = m.alarm_wday_hour[10:8] == m.now_wday_hour[10:8];
   assign day_hit = m.alarm_month_day[5:0] == m.now_month_day[5:0];
   assign month_hit = m.alarm_month_day[12:8] == m.now_month_day[12:8];

   // ----------------------------------------------------------------
   // Interval selection
   // ----------------------------------------------------------------
   always_comb begin
      case (m.interval_mask)
         IVL_HALF_SEC: m.match = m.half_tick;
         IVL_SEC: m.match = m.sec_tick;
         IVL_TEN_SEC: m.match = m.sec_tick & sec_one_hit;
         IVL_MINUTE: m.match = m.sec_tick & sec_hit;
         IVL_TEN_MIN: m.match = m.sec_tick & sec_hit & min_one_hit;
         IVL_HOUR: m.match = m.sec_tick & sec_hit & min_hit;
         IVL_DAY: m.match = m.sec_tick & sec_hit & min_hit & hour_hit;
         IVL_WEEK: m.match = m.sec_tick & sec_hit & min_hit & hour_hit & wday_hit;
         IVL_MONTH: m.match = m.sec_tick & sec_hit & min_hit & hour_hit & day_hit;
         // Leap-day alarm fires every fourth year
         IVL_YEAR: m.match = m.sec_tick & sec_hit & min_hit & hour_hit & day_hit & month_hit;
         // Reserved codes never fire
         default: m.match = 1'b0;
      endcase
   end

endmodule
`default_nettype wire

//--- design/rtc_alarm_config.sv
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Only power-on reset restores the clock configuration register.
// - The module enable bit takes a write only while the value write unlock bit is 1.
// - The half-second flag is read-only and clears when the minutes-seconds lower byte is written.
// - Output source select at pad bit 1 routes seconds clock when 1, alarm pulse when 0.
// - The clock pin carries the selected source only while its output enable bit is set.
// - With wrap on the repeat count rolls from 00h to FFh; with wrap off it stops at 00h.
// - The window pointer decrements on each upper-byte access and holds at 00.
// - The pointer selects minutes/seconds, weekday/hours, month/day; code 11 is empty.
// - The 8-bit repeat count holds how many further alarms remain after the next one.
// - A read of the alarm value window also decrements the window pointer.
// - Month/day and weekday/hours alarm values take writes only while unlocked.
module rtc_alarm_config
   import rtc_alarm_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic soft_reset,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Time base
   input wire logic half_tick,
   input wire logic sec_tick,
   input wire logic seconds_clock,
   input wire logic [15:0] now_min_sec,
   input wire logic [15:0] now_wday_hour,
   input wire logic [15:0] now_month_day,
   // Control outputs
   output logic module_enable,
   output logic [CAL_MSB:0] calibration,
   output logic parallel_port_buffer_select,
   output logic time_write,
   output logic [15:0] time_wdata,
   // Pin and interrupt
   output logic clock_out,
   output logic irq
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [15:0] cfg_ff, nxt_cfg;
   logic [15:0] pad_ff, nxt_pad;
   logic [15:0] alm_ff, nxt_alm;
   logic [15:0] val_ff [3];
   logic [15:0] nxt_val [3];
   logic [15:0] status_ff, nxt_status;
   logic [15:0] mask_ff, nxt_mask;
   logic [31:0] prdata_ff, nxt_prdata;
   logic pready_ff, nxt_pready;
   logic pslverr_ff, nxt_pslverr;
   logic alarm_pulse_ff, nxt_alarm_pulse;
   logic clock_out_ff, nxt_clock_out;
   logic irq_ff, nxt_irq;
   logic time_write_ff, nxt_time_write;
   logic [15:0] time_wdata_ff, nxt_time_wdata;

   logic access;
   logic commit;
   logic mapped;
   logic wr;
   logic rd;
   logic [7:0] addr;
   logic [15:0] rd_data;
   logic [1:0] ptr;
   logic unlocked;
   logic alarm_event;

   alarm_match_if mif ();

   alarm_matcher u_matcher (
      .m(mif.matcher)
   );

   assign mif.interval_mask = alm_ff[ALM_MASK_MSB:ALM_MASK_LSB];
   assign mif.alarm_min_sec = val_ff[PTR_MIN_SEC];
   assign mif.alarm_wday_hour = val_ff[PTR_WDAY_HOUR];
   assign mif.alarm_month_day = val_ff[PTR_MONTH_DAY];
   assign mif.now_min_sec = now_min_sec;
   assign mif.now_wday_hour = now_wday_hour;
   assign mif.now_month_day = now_month_day;
   assign mif.half_tick = half_tick;
   assign mif.sec_tick = sec_tick;

   // ----------------------------------------------------------------
   // Byte-lane merge
   // ----------------------------------------------------------------
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] data,
      input logic [3:0] strb, input logic [15:0] wmask);
      logic [15:0] res;
      res = old;
      for (int b = 0; b < 2; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = (old[b*8 +: 8] & ~wmask[b*8 +: 8]) |
                            (data[b*8 +: 8] & wmask[b*8 +: 8]);
         end
      end
      return res;
   endfunction

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   assign addr = 8'(paddr);
   assign access = psel & penable;
   assign commit = access & pready_ff;
   assign wr = commit & pwrite & mapped;
   assign rd = commit & ~pwrite & mapped;
   assign ptr = alm_ff[ALM_PTR_MSB:ALM_PTR_LSB];
   assign unlocked = cfg_ff[CFG_UNLOCK_BIT];
   assign alarm_event = mif.match & alm_ff[ALM_ENABLE_BIT];

   always_comb begin
      mapped = 1'b1;
      rd_data = 16'h0000;
      if (addr == OFS_CLK_CFG) begin
         rd_data = cfg_ff;
      end else if (addr == OFS_PAD_CFG) begin
         rd_data = pad_ff;
      end else if (addr == OFS_ALM_CFG) begin
         rd_data = alm_ff;
      end else if (addr == OFS_ALM_VAL) begin
         if (ptr != 2'b11) begin
            rd_data = val_ff[ptr];
         end
      end else if (addr == OFS_MIN_SEC) begin
         rd_data = 16'h0000;
      end else if (addr == OFS_IRQ_STATUS) begin
         rd_data = status_ff;
      end else if (addr == OFS_IRQ_MASK) begin
         rd_data = mask_ff;
      end else begin
         mapped = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_cfg = cfg_ff;
      nxt_pad = pad_ff;
      nxt_alm = alm_ff;
      nxt_val = val_ff;
      nxt_status = status_ff;
      nxt_mask = mask_ff;
      nxt_time_write = 1'b0;
      nxt_time_wdata = time_wdata_ff;
      nxt_pready = access & ~pready_ff;
      nxt_prdata = prdata_ff;
      nxt_pslverr = 1'b0;
      if (access & ~pready_ff) begin
         nxt_prdata = {16'h0000, rd_data};
         nxt_pslverr = ~mapped;
      end

      // Half-second flag, tick wins over clear
      if (half_tick) begin
         nxt_cfg[CFG_HALF_SEC_BIT] = ~cfg_ff[CFG_HALF_SEC_BIT];
      end else if (wr & (addr == OFS_MIN_SEC) & pstrb[0]) begin
         nxt_cfg[CFG_HALF_SEC_BIT] = 1'b0;
      end

      // Alarm event handling
      if (alarm_event) begin
         if (alm_ff[ALM_RPT_MSB:0] != RPT_LAST) begin
            nxt_alm[ALM_RPT_MSB:0] = alm_ff[ALM_RPT_MSB:0] - RPT_STEP;
         end else if (alm_ff[ALM_WRAP_BIT]) begin
            nxt_alm[ALM_RPT_MSB:0] = RPT_WRAP_VALUE;
         end else begin
            nxt_alm[ALM_ENABLE_BIT] = 1'b0;
         end
      end

      // Register writes
      if (wr) begin
         if (addr == OFS_CLK_CFG) begin
            nxt_cfg = merge(nxt_cfg, pwdata, pstrb, CFG_WRITE_MASK);
            if (pstrb[1] & unlocked) begin
               nxt_cfg[CFG_ENABLE_BIT] = pwdata[CFG_ENABLE_BIT];
            end
         end else if (addr == OFS_PAD_CFG) begin
            nxt_pad = merge(pad_ff, pwdata, pstrb, PAD_WRITE_MASK);
         end else if (addr == OFS_ALM_CFG) begin
            nxt_alm = merge(alm_ff, pwdata, pstrb, 16'hFFFF);
         end else if (addr == OFS_ALM_VAL) begin
            if (ptr == PTR_MIN_SEC) begin
               nxt_val[PTR_MIN_SEC] = merge(val_ff[PTR_MIN_SEC], pwdata, pstrb, MIN_SEC_MASK);
            end else if (ptr == PTR_WDAY_HOUR && unlocked) begin
               nxt_val[PTR_WDAY_HOUR] = merge(val_ff[PTR_WDAY_HOUR], pwdata, pstrb,
                  WDAY_HOUR_MASK);
            end else if (ptr == PTR_MONTH_DAY && unlocked) begin
               nxt_val[PTR_MONTH_DAY] = merge(val_ff[PTR_MONTH_DAY], pwdata, pstrb,
                  MONTH_DAY_MASK);
            end
            if (pstrb[1] && ptr != PTR_MIN_SEC) begin
               nxt_alm[ALM_PTR_MSB:ALM_PTR_LSB] = ptr - PTR_STEP;
            end
         end else if (addr == OFS_MIN_SEC) begin
            if (unlocked) begin
               nxt_time_write = 1'b1;
               nxt_time_wdata = merge(16'h0000, pwdata, pstrb, MIN_SEC_MASK);
            end
         end else if (addr == OFS_IRQ_MASK) begin
            nxt_mask = merge(mask_ff, pwdata, pstrb, IRQ_WRITE_MASK);
         end
      end

      // Read side effects
      if (rd && addr == OFS_ALM_VAL && ptr != PTR_MIN_SEC) begin
         nxt_alm[ALM_PTR_MSB:ALM_PTR_LSB] = ptr - PTR_STEP;
      end
      if (rd && addr == OFS_IRQ_STATUS) begin
         nxt_status = 16'h0000;
      end
      if (alarm_event) begin
         nxt_status[IRQ_ALARM_BIT] = 1'b1;
      end

      // Soft reset keeps clock config
      if (soft_reset) begin
         nxt_pad = PAD_RESET;
         nxt_alm = ALM_RESET;
         nxt_status = 16'h0000;
         nxt_mask = 16'h0000;
         nxt_time_write = 1'b0;
         nxt_val = '{default: 16'h0000};
      end
   end

   // ----------------------------------------------------------------
   // Pin and interrupt next values
   // ----------------------------------------------------------------
   always_comb begin
      nxt_alarm_pulse = alarm_pulse_ff;
      if (alarm_event) begin
         nxt_alarm_pulse = 1'b1;
      end else if (half_tick) begin
         nxt_alarm_pulse = 1'b0;
      end
      nxt_clock_out = 1'b0;
      if (cfg_ff[CFG_PIN_OE_BIT]) begin
         nxt_clock_out = pad_ff[PAD_SRC_SEL_BIT] ? seconds_clock : alarm_pulse_ff;
      end
      nxt_irq = |(status_ff & mask_ff);
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cfg_ff <= CFG_RESET;
      end else begin
         cfg_ff <= nxt_cfg;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pad_ff <= PAD_RESET;
         alm_ff <= ALM_RESET;
         val_ff <= '{default: 16'h0000};
         status_ff <= 16'h0000;
         mask_ff <= 16'h0000;
         prdata_ff <= 32'h0000_0000;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         alarm_pulse_ff <= 1'b0;
         clock_out_ff <= 1'b0;
         irq_ff <= 1'b0;
         time_write_ff <= 1'b0;
         time_wdata_ff <= 16'h0000;
      end else begin
         pad_ff <= nxt_pad;
         alm_ff <= nxt_alm;
         val_ff <= nxt_val;
         status_ff <= nxt_status;
         mask_ff <= nxt_mask;
         prdata_ff <= nxt_prdata;
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
         alarm_pulse_ff <= nxt_alarm_pulse;
         clock_out_ff <= nxt_clock_out;
         irq_ff <= nxt_irq;
         time_write_ff <= nxt_time_write;
         time_wdata_ff <= nxt_time_wdata;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign module_enable = cfg_ff[CFG_ENABLE_BIT];
   assign calibration = cfg_ff[CAL_MSB:0];
   assign parallel_port_buffer_select = pad_ff[PAD_PORT_BUF_BIT];
   assign time_write = time_write_ff;
   assign time_wdata = time_wdata_ff;
   assign clock_out = clock_out_ff;
   assign irq = irq_ff;

endmodule
`default_nettype wire

//--- bench/rtc_alarm_config_checker.sv
`timescale 1ns/100ps
`default_nettype none
module rtc_alarm_config_checker
   import rtc_alarm_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic soft_reset,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Outputs
   input wire logic module_enable,
   input wire logic [CAL_MSB:0] calibration,
   input wire logic time_write,
   input wire logic [15:0] time_wdata,
   input wire logic irq
);
   // ----------------------------------------
   // Transfer decode
   // ----------------------------------------
   logic commit, cfg_wr, ms_wr, clr_evt, mapped;
   assign commit = psel && penable && pready;
   assign cfg_wr = commit && pwrite && paddr == OFS_CLK_CFG;
   assign ms_wr = commit && pwrite && paddr == OFS_MIN_SEC;
   assign clr_evt = soft_reset || commit && (paddr == OFS_IRQ_STATUS
      || pwrite && paddr == OFS_IRQ_MASK);
   assign mapped = paddr inside {OFS_CLK_CFG, OFS_PAD_CFG, OFS_ALM_CFG, OFS_ALM_VAL,
      OFS_MIN_SEC, OFS_IRQ_STATUS, OFS_IRQ_MASK};
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   property p_one_wait; psel && $rose(penable) |-> !pready ##1 pready; endproperty
   a_one_wait: assert property (p_one_wait) else $error("no wait state");
   property p_err_map; pready |-> pslverr == !mapped; endproperty
   a_err_map: assert property (p_err_map) else $error("bad pslverr");
   property p_upper_zero; pready && !pwrite |-> prdata[31:16] == 16'h0000; endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper half set");
   property p_soft_keep;
      soft_reset && !cfg_wr |=> $stable(calibration) && $stable(module_enable);
   endproperty
   a_soft_keep: assert property (p_soft_keep) else $error("config lost");
   property p_en_write; !$stable(module_enable) |-> $past(cfg_wr); endproperty
   a_en_write: assert property (p_en_write) else $error("enable moved");
   property p_ms_pulse; time_write |-> $past(ms_wr) ##1 !time_write; endproperty
   a_ms_pulse: assert property (p_ms_pulse) else $error("bad time pulse");
   property p_ms_mask; time_write |-> (time_wdata & ~MIN_SEC_MASK) == 16'h0000; endproperty
   a_ms_mask: assert property (p_ms_mask) else $error("time data unmasked");
   property p_irq_fall; $fell(irq) |-> $past(clr_evt) || $past(clr_evt, 2); endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq fell early");
   c_cfg_wr: cover property (cfg_wr);
   c_time_write: cover property (time_write);
   c_irq: cover property ($rose(irq));
endmodule
bind rtc_alarm_config rtc_alarm_config_checker #(.ADDR_W(ADDR_W)) i_chk (
   .clk, .resetn, .soft_reset, .psel, .penable, .pwrite, .paddr, .prdata,
   .pready, .pslverr, .module_enable, .calibration, .time_write, .time_wdata, .irq
);
`default_nettype wire

//--- bench/rtc_alarm_config_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
   $display("wrong value %s exp %h got %h", nm, e, g); end end
module rtc_alarm_config_tb import rtc_alarm_pkg::*;;
   logic clk = 1'b0;
   logic resetn, soft_reset, psel, penable, pwrite, pready, pslverr, rerr;
   logic half_tick, sec_tick, seconds_clock, module_enable, time_write, clock_out, irq;
   logic parallel_port_buffer_select, en, e;
   logic [7:0] paddr, calibration, r;
   logic [3:0] pstrb;
   logic [31:0] pwdata, prdata, rdata;
   logic [15:0] now_min_sec, now_wday_hour, now_month_day, time_wdata, c, v;
   int err_count = 0, checks = 0;
   rtc_alarm_config i_dut (
      .clk, .resetn, .soft_reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
      .pready, .pslverr, .half_tick, .sec_tick, .seconds_clock, .now_min_sec, .now_wday_hour,
      .now_month_day, .module_enable, .calibration, .parallel_port_buffer_select,
      .time_write, .time_wdata, .clock_out, .irq
   );
   initial forever #5 clk = ~clk;
   // ----------------------------------------
   // Expectations and bus tasks
   // ----------------------------------------
   function automatic logic [15:0] alm(input logic n, w, input logic [3:0] m,
      input logic [1:0] p, input logic [7:0] k);
      return {n, w, m, p, k};
   endfunction
   function automatic logic [7:0] nxt_rpt(input logic [7:0] k, input logic w);
      return k != RPT_LAST ? k - RPT_STEP : (w ? RPT_WRAP_VALUE : RPT_LAST);
   endfunction
   function automatic logic [15:0] page(input logic [1:0] p);
      case (p)
         PTR_MIN_SEC: return now_min_sec & MIN_SEC_MASK;
         PTR_WDAY_HOUR: return now_wday_hour & WDAY_HOUR_MASK;
         PTR_MONTH_DAY: return now_month_day & MONTH_DAY_MASK;
         default: return 16'h0000;
      endcase
   endfunction
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d,
      input logic [3:0] s);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         err_count++;
         end_sim();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      apb(1'b1, a, d, 4'hF);
   endtask
   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 16'h0000, 4'hF);
   endtask
   task automatic tick(input logic s);
      @(posedge clk);
      {half_tick, sec_tick} <= {1'b1, s};
      @(posedge clk);
      {half_tick, sec_tick} <= 2'b00;
      repeat (3) @(posedge clk);
   endtask
   initial begin
      {resetn, soft_reset, psel, penable, pwrite, half_tick, sec_tick, seconds_clock} = '0;
      {paddr, pwdata, pstrb} = '0;
      void'($urandom(94030));
      now_min_sec = 16'($urandom()) & MIN_SEC_MASK;
      now_wday_hour = 16'($urandom()) & WDAY_HOUR_MASK;
      now_month_day = 16'($urandom()) & MONTH_DAY_MASK;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      rd(OFS_CLK_CFG);
      `CHK("cfg reset", {16'h0000, CFG_RESET}, rdata)
      rd(OFS_PAD_CFG);
      `CHK("pad reset", {16'h0000, PAD_RESET}, rdata)
      rd(OFS_ALM_CFG);
      `CHK("alarm reset", {16'h0000, ALM_RESET}, rdata)
      rd(8'h1C);
      `CHK("unmapped", 1'b1, rerr)
      $display("test reset done");
      c = 16'h8000 | 16'($urandom_range(255));
      wr(OFS_CLK_CFG, c);
      @(negedge clk);
      `CHK("enable locked", 1'b0, module_enable)
      `CHK("calibration", c[7:0], calibration)
      wr(OFS_CLK_CFG, c | 16'h2000);
      wr(OFS_CLK_CFG, c | 16'h2000);
      @(negedge clk);
      `CHK("enable open", 1'b1, module_enable)
      @(posedge clk);
      soft_reset <= 1'b1;
      @(posedge clk);
      soft_reset <= 1'b0;
      rd(OFS_CLK_CFG);
      `CHK("cfg kept", {16'h0000, c | 16'h2000}, rdata)
      $display("test enable done");
      tick(1'b0);
      rd(OFS_CLK_CFG);
      `CHK("half set", 1'b1, rdata[CFG_HALF_SEC_BIT])
      v = 16'($urandom());
      apb(1'b1, OFS_MIN_SEC, v, 4'b0001);
      wr(OFS_CLK_CFG, c | 16'h2800);
      rd(OFS_CLK_CFG);
      `CHK("half clear", {16'h0000, c | 16'h2000}, rdata)
      `CHK("time data", v & MIN_SEC_MASK & 16'h00FF, time_wdata)
      $display("test half flag done");
      wr(OFS_PAD_CFG, 16'hFFFF);
      rd(OFS_PAD_CFG);
      `CHK("pad bits", {16'h0000, PAD_WRITE_MASK}, rdata)
      `CHK("buffer sel", 1'b1, parallel_port_buffer_select)
      seconds_clock <= 1'b1;
      repeat (3) @(negedge clk);
      `CHK("pin off", 1'b0, clock_out)
      wr(OFS_CLK_CFG, c | 16'h2400);
      repeat (3) @(negedge clk);
      `CHK("pin sec high", 1'b1, clock_out)
      @(posedge clk) seconds_clock <= 1'b0;
      repeat (3) @(negedge clk);
      `CHK("pin sec low", 1'b0, clock_out)
      $display("test pin done");
      wr(OFS_ALM_CFG, alm(1'b0, 1'b0, 4'h0, PTR_MONTH_DAY, 8'h00));
      wr(OFS_ALM_VAL, now_month_day);
      wr(OFS_ALM_VAL, now_wday_hour);
      wr(OFS_ALM_VAL, now_min_sec);
      rd(OFS_ALM_CFG);
      `CHK("ptr stop", PTR_MIN_SEC, rdata[9:8])
      wr(OFS_ALM_CFG, alm(1'b0, 1'b0, 4'h0, PTR_MONTH_DAY, 8'h00));
      for (int i = 0; i < 4; i++) begin
         rd(OFS_ALM_VAL);
         `CHK("window", {16'h0000, page(2'(i < 2 ? 2 - i : 0))}, rdata)
      end
      wr(OFS_ALM_CFG, alm(1'b0, 1'b0, 4'h0, 2'b11, 8'h00));
      rd(OFS_ALM_VAL);
      `CHK("page 11", 32'h0000_0000, rdata)
      rd(OFS_ALM_CFG);
      `CHK("ptr from 11", PTR_MONTH_DAY, rdata[9:8])
      wr(OFS_CLK_CFG, c | 16'h0400);
      wr(OFS_ALM_VAL, ~now_month_day);
      wr(OFS_ALM_CFG, alm(1'b0, 1'b0, 4'h0, PTR_MONTH_DAY, 8'h00));
      rd(OFS_ALM_VAL);
      `CHK("locked page", {16'h0000, page(PTR_MONTH_DAY)}, rdata)
      wr(OFS_CLK_CFG, c | 16'h2400);
      $display("test window done");
      wr(OFS_IRQ_MASK, 16'h0001);
      for (int m = 0; m < 10; m++) begin
         r = 8'($urandom_range(255, 1));
         wr(OFS_ALM_CFG, alm(1'b1, 1'b0, 4'(m), PTR_MIN_SEC, r));
         tick(1'b1);
         `CHK("irq", 1'b1, irq)
         rd(OFS_ALM_CFG);
         `CHK("code", {16'h0000, alm(1'b1, 1'b0, 4'(m), 2'b00, nxt_rpt(r, 1'b0))}, rdata)
         rd(OFS_IRQ_STATUS);
         `CHK("status", 32'h0000_0001, rdata)
      end
      now_min_sec <= now_min_sec ^ 16'h0001;
      wr(OFS_ALM_CFG, alm(1'b1, 1'b0, IVL_MINUTE, PTR_MIN_SEC, 8'h05));
      tick(1'b1);
      rd(OFS_ALM_CFG);
      `CHK("no match", {16'h0000, alm(1'b1, 1'b0, IVL_MINUTE, 2'b00, 8'h05)}, rdata)
      wr(OFS_ALM_CFG, alm(1'b1, 1'b0, IVL_HALF_SEC, PTR_MIN_SEC, 8'h05));
      tick(1'b1);
      rd(OFS_ALM_CFG);
      `CHK("half code", {16'h0000, alm(1'b1, 1'b0, 4'h0, 2'b00, 8'h04)}, rdata)
      rd(OFS_IRQ_STATUS);
      `CHK("status", 32'h0000_0001, rdata)
      $display("test codes done");
      wr(OFS_IRQ_MASK, 16'h0000);
      wr(OFS_PAD_CFG, 16'h0000);
      for (int w = 0; w < 2; w++) begin
         en = 1'b1;
         r = w[0] ? RPT_LAST : 8'h01;
         wr(OFS_ALM_CFG, alm(en, w[0], IVL_HALF_SEC, PTR_MIN_SEC, r));
         repeat (3) begin
            tick(1'b1);
            e = en;
            `CHK("pin pulse", e, clock_out)
            `CHK("irq masked", 1'b0, irq)
            if (en) begin
               en = r != RPT_LAST || w[0];
               r = nxt_rpt(r, w[0]);
            end
            rd(OFS_ALM_CFG);
            `CHK("repeat", {16'h0000, alm(en, w[0], 4'h0, 2'b00, r)}, rdata)
            rd(OFS_IRQ_STATUS);
            `CHK("status", {31'h0, e}, rdata)
         end
      end
      $display("test repeat done");
      end_sim();
   end
endmodule
`default_nettype wire
